// ---- rtl/dic_pkg.sv ----
package dic_pkg;

   // APB register byte offsets
   localparam logic [7:0] MASK_OFS    = 8'h00;
   localparam logic [7:0] CTRL_OFS    = 8'h04;
   localparam logic [7:0] FORCE_OFS   = 8'h08;
   localparam logic [7:0] PEND_OFS    = 8'h0C;
   localparam logic [7:0] CORE_OFS    = 8'h10;
   localparam logic [7:0] STATUS_OFS  = 8'h14;
   localparam logic [7:0] VECTOR_OFS  = 8'h18;
   localparam logic [7:0] MODE_OFS    = 8'h1C;

   localparam int NSRC = 11;

   // Source index in descending priority
   localparam int SRC_PWD   = 0;
   localparam int SRC_REQ2  = 1;
   localparam int SRC_LVL1  = 2;
   localparam int SRC_LVL0  = 3;
   localparam int SRC_P0TX  = 4;
   localparam int SRC_P0RX  = 5;
   localparam int SRC_EDGE  = 6;
   localparam int SRC_BYTE  = 7;
   localparam int SRC_P1TX  = 8;
   localparam int SRC_P1RX  = 9;
   localparam int SRC_TIMER = 10;

   localparam logic [15:0] VEC_RESET = 16'h0000;
   localparam logic [15:0] VEC_PWD   = 16'h002C;
   localparam logic [15:0] VEC_STEP  = 16'h0004;
   localparam logic [15:0] BOOT_ADDR = 16'h0000;

   // Control register fields
   localparam int CTL_REQ2_EDGE = 0;
   localparam int CTL_ALT0_EDGE = 1;
   localparam int CTL_ALT1_EDGE = 2;
   localparam int CTL_NEST      = 3;
   localparam int CTL_XTAL_OFF  = 4;
   localparam int CTL_CONTEXT   = 5;
   localparam int CTL_PORT1_ALT = 6;
   localparam logic [6:0] CTRL_RESET = 7'h00;
   localparam logic [10:0] MASK_RESET = 11'h000;

   // Core command register codes (write data bits 2:0)
   localparam logic [2:0] CMD_ENA   = 3'h1;
   localparam logic [2:0] CMD_DIS   = 3'h2;
   localparam logic [2:0] CMD_IDLE  = 3'h3;
   localparam logic [2:0] CMD_RTI   = 3'h4;
   localparam logic [2:0] CMD_PDOWN = 3'h5;

   localparam int STACK_DEPTH = 12;

   // Timing in master-clock cycles
   localparam int WAKE_FAST_CYC = 200;
   localparam int WAKE_XTAL_CYC = 4096;

   typedef struct packed {
      logic ext_request_two_n;
      logic level_request_one_n;
      logic level_request_zero_n;
      logic edge_request_pin_n;
      logic port1_alt_request_one_n;
      logic port1_alt_request_zero_n;
      logic powerdown_request_pin_n;
   } dic_pins_t;

   typedef struct packed {
      logic port0_tx;
      logic port0_rx;
      logic byte_xfer;
      logic port1_tx;
      logic port1_rx;
      logic timer;
   } dic_events_t;

endpackage : dic_pkg

// ---- rtl/dic_ctrl.sv ----
`timescale 1ns/100ps
`default_nettype none

// Operation
// R01 - Fixed priority over eleven sources and reset; power-down unmaskable
// R02 - Level or edge chosen by software for request two and port1 pins
// R03 - The two low-priority level pins are level only; code ranks them third and fourth of eleven
// R04 - Edge pin is edge only; software can force or clear it
// R05 - Vectors: reset 0000, power-down 002C, then 0004 up to timer 0028
// R06 - Pending AND mask, highest remaining request selected
// R07 - Nesting control selects preemptive nesting or sequential servicing
// R08 - All interrupts blocked one cycle after a mask write
// R09 - Write-only force/clear register; reads return zero
// R10 - Status pushed and popped on a twelve-level shared stack
// R11 - Global enable and disable gate all servicing, power-down included
// R12 - Global servicing enabled after reset
// R13 - Resume from power-down within 200 master cycles when clock runs
// R14 - About 4096 master cycles wait when oscillator was stopped
// R15 - Power-down from pin or force bit, nonmaskable edge interrupt
// R16 - Leaving power-down restores context or starts cleared per control
// R17 - Reset ends power-down
// R18 - Acknowledge output shows power-down actually entered
// R19 - Idle waits for unmasked interrupt, then continues after idle
// R20 - Divided idle accepts 16, 32, 64 or 128 and slows clocks
// R21 - Divided idle resumes within divisor cycles of an enabled interrupt
// R22 - Reset empties stacks, masks all, clears mode status, boots at 0000
// R23 - Latched edge requests stay pending until taken or cleared
module dic_ctrl #(
   parameter int WAKE_XTAL = dic_pkg::WAKE_XTAL_CYC
) (
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic [7:0]        paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   input  wire dic_pkg::dic_pins_t   pins,
   input  wire dic_pkg::dic_events_t events,
   output logic                   irq_take,
   output logic      [15:0]       irq_vector,
   output logic      [15:0]       fetch_addr,
   output logic                   core_running,
   output logic                   slow_clk_en,
   output logic                   powerdown_ack_pin
);
   import dic_pkg::*;

   if (WAKE_XTAL < WAKE_FAST_CYC || WAKE_XTAL > 8192) begin : g_bad_wake
      $error("WAKE_XTAL outside the 13-bit wake counter range");
   end

   typedef enum {RUN, IDLE, PDOWN, WAKE} dic_state_t;

   logic [6:0]        pin_s1_reg, pin_s2_reg, pin_d_reg;
   logic [NSRC-1:0]   mask_reg, pend_reg, active_reg;
   logic [6:0]        ctrl_reg;
   logic              gie_reg, block_reg;
   logic [1:0]        div_sel_reg;
   logic [6:0]        div_cnt_reg;
   logic [15:0]       mode_status_reg;
   logic [3:0]        sp_reg;
   logic [NSRC+15:0]  stack_mem [STACK_DEPTH];
   logic [12:0]       wake_cnt_reg;
   logic              xtal_stopped_reg;
   dic_state_t        state_reg;

   logic              wr, rd;
   logic [NSRC-1:0]   act_lvl, edge_hit, eligible, winner, above;
   logic              take, ret, push_ok;
   logic [2:0]        cmd;
   logic [3:0]        win_idx;

   assign wr      = psel & penable & pwrite;
   assign rd      = psel & penable & ~pwrite;
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign cmd     = pwdata[2:0];

   // Pins are asynchronous, active low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_reg <= 7'h7F;
         pin_s2_reg <= 7'h7F;
         pin_d_reg  <= 7'h7F;
      end else begin
         pin_s1_reg <= pins;
         pin_s2_reg <= pin_s1_reg;
         pin_d_reg  <= pin_s2_reg;
      end
   end

   // Pin order follows dic_pins_t: 6 req2, 5 lvl1, 4 lvl0, 3 edge,
   // 2 alt1, 1 alt0, 0 power-down
   always_comb begin
      act_lvl  = '0;
      edge_hit = '0;
      act_lvl[SRC_REQ2]  = ~pin_s2_reg[6];
      act_lvl[SRC_LVL1]  = ~pin_s2_reg[5];                 // see R03
      act_lvl[SRC_LVL0]  = ~pin_s2_reg[4];                 // see R03
      edge_hit[SRC_PWD]  = pin_d_reg[0] & ~pin_s2_reg[0];  // see R15
      edge_hit[SRC_EDGE] = pin_d_reg[3] & ~pin_s2_reg[3];  // see R04
      edge_hit[SRC_REQ2] = pin_d_reg[6] & ~pin_s2_reg[6];
      edge_hit[SRC_P0TX] = events.port0_tx;
      edge_hit[SRC_P0RX] = events.port0_rx;
      edge_hit[SRC_BYTE] = events.byte_xfer;
      edge_hit[SRC_TIMER] = events.timer;
      if (ctrl_reg[CTL_PORT1_ALT]) begin
         act_lvl[SRC_P1TX]  = ~pin_s2_reg[2];
         act_lvl[SRC_P1RX]  = ~pin_s2_reg[1];
         edge_hit[SRC_P1TX] = pin_d_reg[2] & ~pin_s2_reg[2];
         edge_hit[SRC_P1RX] = pin_d_reg[1] & ~pin_s2_reg[1];
      end else begin
         edge_hit[SRC_P1TX] = events.port1_tx;
         edge_hit[SRC_P1RX] = events.port1_rx;
      end
   end

   // Per-source mode: level sources track the pin, edge ones latch
   logic [NSRC-1:0] is_level;
   always_comb begin
      is_level = '0;
      is_level[SRC_LVL1] = 1'b1;
      is_level[SRC_LVL0] = 1'b1;
      is_level[SRC_REQ2] = ~ctrl_reg[CTL_REQ2_EDGE];          // see R02
      is_level[SRC_P1TX] = ctrl_reg[CTL_PORT1_ALT] &
                           ~ctrl_reg[CTL_ALT1_EDGE];           // see R02
      is_level[SRC_P1RX] = ctrl_reg[CTL_PORT1_ALT] &
                           ~ctrl_reg[CTL_ALT0_EDGE];           // see R02
   end

   logic force_wr;
   assign force_wr = wr && paddr == FORCE_OFS;

   // Force in bits 10:0, clear in bits 26:16; new edge wins over clear
   generate
      for (genvar i = 0; i < NSRC; i++) begin : g_pend
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pend_reg[i] <= 1'b0;
            end else if (is_level[i]) begin
               pend_reg[i] <= act_lvl[i];
            end else if (edge_hit[i] || (force_wr && pwdata[i])) begin
               pend_reg[i] <= 1'b1;                      // see R09, R23
            end else if ((take && winner[i]) ||
                         (force_wr && pwdata[16+i])) begin
               pend_reg[i] <= 1'b0;                      // see R23
            end
         end
      end
   endgenerate

   // Power-down bit is never masked
   assign eligible = pend_reg &
                     (mask_reg | (11'h001 << SRC_PWD));  // see R01, R06

   // Nesting: only sources above the highest active one may preempt
   // Bit i allowed if no active source at index <= i
   always_comb begin
      above    = '0;
      above[0] = ~active_reg[0];
      for (int i = 1; i < NSRC; i++) begin
         above[i] = above[i-1] & ~active_reg[i];
      end
   end

   always_comb begin
      winner  = '0;
      win_idx = 4'h0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            winner  = '0;
            winner[i] = 1'b1;                            // see R01, R06
            win_idx = 4'(i);
         end
      end
   end

   assign push_ok = sp_reg < 4'(STACK_DEPTH);
   assign take = |eligible && gie_reg && !block_reg && push_ok &&  // see R08, R11
                 (ctrl_reg[CTL_NEST] ? |(winner & above)           // see R07
                                     : active_reg == '0) &&
                 (state_reg == RUN || state_reg == IDLE) &&
                 (state_reg != IDLE || slow_clk_en);                // see R21
   assign ret = wr && paddr == CORE_OFS && cmd == CMD_RTI && sp_reg != 4'h0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_take   <= 1'b0;
         irq_vector <= VEC_RESET;
      end else begin
         irq_take   <= take;
         if (take) begin
            irq_vector <= winner[SRC_PWD] ? VEC_PWD :      // see R05
                          16'(VEC_STEP * win_idx);
         end
      end
   end

   // Status stack pushed on interrupt take, popped on RTI
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sp_reg     <= 4'h0;                             // see R22
         active_reg <= '0;
      end else if (take) begin
         stack_mem[sp_reg] <= {active_reg, mode_status_reg}; // see R10
         sp_reg     <= sp_reg + 4'h1;
         active_reg <= active_reg | winner;
      end else if (ret) begin
         sp_reg     <= sp_reg - 4'h1;                    // see R10
         active_reg <= stack_mem[sp_reg - 4'h1][NSRC+15:16];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg  <= MASK_RESET;                        // see R22
         block_reg <= 1'b0;
      end else begin
         block_reg <= wr && paddr == MASK_OFS;           // see R08
         if (wr && paddr == MASK_OFS) begin
            mask_reg <= pwdata[NSRC-1:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= CTRL_RESET;
      end else if (wr && paddr == CTRL_OFS) begin
         ctrl_reg <= pwdata[6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gie_reg <= 1'b1;                                // see R12
      end else if (wr && paddr == CORE_OFS && cmd == CMD_ENA) begin
         gie_reg <= 1'b1;                                // see R11
      end else if (wr && paddr == CORE_OFS && cmd == CMD_DIS) begin
         gie_reg <= 1'b0;                                // see R11
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_status_reg <= 16'h0000;                    // see R22
      end else if (state_reg == WAKE && wake_cnt_reg == 13'h0000 &&
                   !ctrl_reg[CTL_CONTEXT]) begin
         mode_status_reg <= 16'h0000;                    // see R16
      end else if (wr && paddr == MODE_OFS) begin
         mode_status_reg <= pwdata[15:0];
      end
   end

   // Power-down, idle and wake sequencing
   logic idle_cmd, pd_cmd;
   assign idle_cmd = wr && paddr == CORE_OFS && cmd == CMD_IDLE;
   assign pd_cmd   = wr && paddr == CORE_OFS && cmd == CMD_PDOWN;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg        <= RUN;                        // see R17
         wake_cnt_reg     <= 13'h0000;
         xtal_stopped_reg <= 1'b0;
         div_sel_reg      <= 2'h0;
      end else begin
         case (state_reg)
            RUN: begin
               if (pd_cmd) begin
                  state_reg        <= PDOWN;             // see R15
                  xtal_stopped_reg <= ctrl_reg[CTL_XTAL_OFF];
               end else if (idle_cmd) begin
                  state_reg   <= IDLE;                   // see R19
                  div_sel_reg <= pwdata[5:4];            // see R20
               end
            end
            IDLE: begin
               if (take) begin
                  state_reg   <= RUN;                    // see R19
                  div_sel_reg <= 2'h0;
               end
            end
            PDOWN: begin
               if (edge_hit[SRC_PWD] || act_lvl[SRC_LVL0]) begin
                  state_reg    <= WAKE;
                  wake_cnt_reg <= xtal_stopped_reg ?     // see R14
                                  13'(WAKE_XTAL - 1) :
                                  13'(WAKE_FAST_CYC - 1); // see R13
               end
            end
            WAKE: begin
               if (wake_cnt_reg == 13'h0000) begin
                  state_reg <= RUN;                      // see R16
               end else begin
                  wake_cnt_reg <= wake_cnt_reg - 13'h0001;
               end
            end
            default: state_reg <= RUN;
         endcase
      end
   end

   // Divided-idle enable; code 0 divides by 16
   logic [6:0] div_max;
   always_comb begin
      case (div_sel_reg)
         2'h0:    div_max = 7'h0F;                       // see R20
         2'h1:    div_max = 7'h1F;
         2'h2:    div_max = 7'h3F;
         default: div_max = 7'h7F;
      endcase
   end

   logic in_slow;
   assign in_slow = state_reg == IDLE;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_cnt_reg <= 7'h00;
      end else if (state_reg != IDLE || div_cnt_reg >= div_max) begin
         div_cnt_reg <= 7'h00;                           // see R21
      end else begin
         div_cnt_reg <= div_cnt_reg + 7'h01;
      end
   end

   // Every idle is divided, so response waits for the next slow tick
   assign slow_clk_en = state_reg != IDLE || div_cnt_reg >= div_max;
   assign core_running = state_reg == RUN;
   assign fetch_addr   = BOOT_ADDR;                      // see R22

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         powerdown_ack_pin <= 1'b0;
      end else begin
         powerdown_ack_pin <= state_reg == PDOWN;        // see R18
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            MASK_OFS:   prdata <= 32'(mask_reg);
            CTRL_OFS:   prdata <= 32'(ctrl_reg);
            PEND_OFS:   prdata <= 32'(pend_reg);
            STATUS_OFS: prdata <= {22'h0, state_reg == PDOWN, gie_reg,
                                   sp_reg, 4'(in_slow)};
            VECTOR_OFS: prdata <= 32'(irq_vector);
            MODE_OFS:   prdata <= 32'(mode_status_reg);
            default:    prdata <= 32'h0000_0000;         // see R09
         endcase
      end
   end

endmodule : dic_ctrl

`default_nettype wire

// ---- dv/dic_ctrl_assertions.sv ----
`timescale 1ns/100ps
`default_nettype none
module dic_ctrl_assertions #(
   parameter int WAKE_XTAL = dic_pkg::WAKE_XTAL_CYC
) (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic [7:0]           paddr,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire dic_pkg::dic_pins_t   pins,
   input wire dic_pkg::dic_events_t events,
   input wire logic                 irq_take,
   input wire logic [15:0]          irq_vector,
   input wire logic [15:0]          fetch_addr,
   input wire logic                 core_running,
   input wire logic                 slow_clk_en,
   input wire logic                 powerdown_ack_pin
);
   import dic_pkg::*;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   a_zero_wait: assert property (psel && penable |-> pready)
      else $error("access not answered at once");
   a_no_error: assert property (psel && penable |-> !pslverr)
      else $error("slave error raised");
   a_boot_fetch: assert property (fetch_addr == BOOT_ADDR)
      else $error("first fetch address wrong");
   a_vector_on_take: assert property ($changed(irq_vector) |-> irq_take)
      else $error("vector moved without a take");
   a_vector_legal: assert property (irq_take |-> irq_vector[1:0] == 2'b00
      && irq_vector >= VEC_STEP && irq_vector <= VEC_PWD)
      else $error("vector outside table");
   a_ack_stops_core: assert property (powerdown_ack_pin |-> !core_running)
      else $error("core runs while acknowledged down");
   a_slow_in_idle: assert property (!slow_clk_en |-> !core_running)
      else $error("clock divided while running");
   a_reset_ends_pd: assert property (disable iff (1'b0)
      !presetn |-> !powerdown_ack_pin)
      else $error("power-down survives reset");

   c_pd_vector: cover property (irq_take && irq_vector == VEC_PWD);
   c_pd_entered: cover property ($rose(powerdown_ack_pin));
   c_slow_idle: cover property (!slow_clk_en);
endmodule : dic_ctrl_assertions

bind dic_ctrl dic_ctrl_assertions #(.WAKE_XTAL(WAKE_XTAL)) u_chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .pins(pins), .events(events),
   .irq_take(irq_take), .irq_vector(irq_vector), .fetch_addr(fetch_addr),
   .core_running(core_running), .slow_clk_en(slow_clk_en),
   .powerdown_ack_pin(powerdown_ack_pin));
`default_nettype wire

// ---- dv/dic_src_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module dic_src_model (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 irq_take,
   output var  dic_pkg::dic_pins_t   pins,
   output var  dic_pkg::dic_events_t events
);
   import dic_pkg::*;
   logic [6:0] pls = '1;
   logic [6:0] lvl = '1;
   initial events = '0;
   assign pins = dic_pins_t'(pls & lvl);

   // Short falling pulse, power-down pin included
   task automatic pin_pulse(input int i);
      fork
         begin
            pls[i] <= 1'b0;
            repeat (4) @(posedge pclk);
            pls[i] <= 1'b1;
         end
      join_none
   endtask : pin_pulse

   task lvl_hold(input int i);
      lvl[i] <= 1'b0;
   endtask : lvl_hold

   task evt_pulse(input int i);
      events[i] <= 1'b1;
      @(posedge pclk);
      events <= '0;
   endtask : evt_pulse

   // A level source drops once served, else it would re-enter at once
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         lvl <= '1;
      else if (irq_take)
         lvl <= '1;
   end
endmodule : dic_src_model
`default_nettype wire

// ---- dv/testbench.sv ----
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import dic_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        irq_take, core_running, slow_clk_en, powerdown_ack_pin;
   logic [15:0] irq_vector, fetch_addr;
   dic_pins_t   pins;
   dic_events_t events;
   int          fails, cmp_count, cyc, tk_n;

   initial pclk = 1'b0;
   always #5 pclk = ~pclk;

   dic_ctrl #(.WAKE_XTAL(300)) dut (.pclk(pclk), .presetn(presetn),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .pins(pins), .events(events), .irq_take(irq_take),
      .irq_vector(irq_vector), .fetch_addr(fetch_addr),
      .core_running(core_running), .slow_clk_en(slow_clk_en),
      .powerdown_ack_pin(powerdown_ack_pin));
   dic_src_model src (.pclk(pclk), .presetn(presetn), .irq_take(irq_take),
      .pins(pins), .events(events));

   task conclude;
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : conclude

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails = fails + 1;
         conclude();
      end
   end

   task chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         fails++;
         $display("BAD %0t got %h expected %h", $time, g, e);
      end
   endtask : chk

   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask : apb

   task wr(input logic [7:0] a, input logic [31:0] d); apb(1, a, d); endtask : wr
   task rd(input logic [7:0] a); apb(0, a, 32'h0000_0000); endtask : rd
   task rti; wr(CORE_OFS, {29'h0, CMD_RTI}); endtask : rti

   task take(input logic [15:0] e);
      tk_n = 0;
      do begin @(posedge pclk); tk_n++; end
      while (irq_take !== 1'b1 && tk_n < 300);
      chk(irq_take, 1);
      chk(irq_vector, e);
   endtask : take

   task quiet(input int n);
      int k;
      k = 0;
      repeat (n) begin @(posedge pclk); if (irq_take !== 1'b0) k++; end
      chk(k, 0);
   endtask : quiet

   task rst;
      presetn <= 1'b0;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask : rst

   task t_regs;
      rd(MASK_OFS); chk(q, 32'h0000_0000);
      rd(CTRL_OFS); chk(q, 32'h0000_0000);
      rd(STATUS_OFS); chk(q, 32'h0000_0100);
      wr(FORCE_OFS, 32'h0000_0000);
      rd(FORCE_OFS); chk(q, 32'h0000_0000);
      rd(8'h40); chk(q, 32'h0000_0000);
      chk(fetch_addr, BOOT_ADDR);
   endtask : t_regs

   task t_vectors;
      wr(MASK_OFS, 32'h0000_07FF);
      wr(CTRL_OFS, 32'h0000_0001);
      for (int i = 0; i < NSRC; i++) begin
         // Level sources follow their pins, so force cannot hold them
         if (i == SRC_LVL1 || i == SRC_LVL0)
            src.lvl_hold(i == SRC_LVL1 ? 5 : 4);
         else
            wr(FORCE_OFS, 32'h1 << i);
         take(i == 0 ? VEC_PWD : 16'(i * 4));
         rti();
      end
      wr(MASK_OFS, 32'h0000_0000);
      wr(FORCE_OFS, 32'h0000_0001);
      take(VEC_PWD);
      rti();
   endtask : t_vectors

   task t_prio;
      wr(MASK_OFS, 32'h0000_07FF);
      wr(CORE_OFS, {29'h0, CMD_DIS});
      wr(FORCE_OFS, 32'h0000_0403);
      quiet(20);
      wr(CORE_OFS, {29'h0, CMD_ENA});
      take(VEC_PWD);
      quiet(20);
      rti(); take(16'h0004); rti();
      take(16'h0028); rti();
      wr(CTRL_OFS, 32'h0000_0009);
      wr(FORCE_OFS, 32'h0000_0400);
      take(16'h0028);
      wr(FORCE_OFS, 32'h0000_0002);
      take(16'h0004);
      rti(); rti();
      wr(CTRL_OFS, 32'h0000_0000);
   endtask : t_prio

   task t_edge;
      wr(MASK_OFS, 32'h0000_0000);
      src.pin_pulse(3);
      quiet(8);
      rd(PEND_OFS); chk(q, 32'h0000_0040);
      wr(FORCE_OFS, 32'h0040_0000);
      rd(PEND_OFS); chk(q, 32'h0000_0000);
      src.pin_pulse(3);
      repeat (8) @(posedge pclk);
      wr(MASK_OFS, 32'h0000_07FF);
      take(16'h0018); rti();
   endtask : t_edge

   task t_sources;
      logic [15:0] ev_vec [6];
      ev_vec = '{16'h0028, 16'h0024, 16'h0020, 16'h001C, 16'h0014, 16'h0010};
      for (int i = 0; i < 6; i++) begin
         src.evt_pulse(i); take(ev_vec[i]); rti();
      end
      src.lvl_hold(4); take(16'h000C); rti();
      src.lvl_hold(5); take(16'h0008); rti();
      wr(CTRL_OFS, 32'h0000_0001);
      src.pin_pulse(6); take(16'h0004); rti();
      wr(CTRL_OFS, 32'h0000_0040);
      src.lvl_hold(2); take(16'h0020); rti();
      src.lvl_hold(1); take(16'h0024); rti();
      wr(CTRL_OFS, 32'h0000_0046);
      src.pin_pulse(1); take(16'h0024); rti();
      wr(CTRL_OFS, 32'h0000_0000);
      src.lvl_hold(6); take(16'h0004); rti();
   endtask : t_sources

   task t_idle;
      int k;
      for (int c = 0; c < 4; c++) begin
         wr(CORE_OFS, {26'h0, 2'(c), 1'b0, CMD_IDLE});
         repeat (3) @(posedge pclk);
         k = 0;
         repeat (128) begin @(posedge pclk); if (slow_clk_en === 1'b1) k++; end
         chk(k, 128 >> (4 + c));
         chk(core_running, 0);
         src.evt_pulse(0);
         take(16'h0028);
         chk(tk_n <= (16 << c) + 8, 1);
         rti();
      end
   endtask : t_idle

   task t_pd(input logic xtal);
      int n;
      rst();
      wr(CTRL_OFS, xtal ? 32'h0000_0010 : 32'h0000_0000);
      wr(CORE_OFS, {29'h0, CMD_PDOWN});
      repeat (10) @(posedge pclk);
      chk(powerdown_ack_pin, 1);
      chk(core_running, 0);
      src.pin_pulse(0);
      n = 0;
      do begin @(posedge pclk); n++; end
      while (core_running !== 1'b1 && n < 1000);
      if (xtal)
         chk(n >= 295 && n <= 320, 1);
      else
         chk(n <= 210, 1);
      chk(powerdown_ack_pin, 0);
   endtask : t_pd

   task t_reset_pd;
      wr(CORE_OFS, {29'h0, CMD_PDOWN});
      repeat (10) @(posedge pclk);
      chk(powerdown_ack_pin, 1);
      presetn <= 1'b0;
      @(posedge pclk);
      #1 chk(powerdown_ack_pin, 0);
      rst();
   endtask : t_reset_pd

   initial begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0000_0000;
      fails = 0; cmp_count = 0;
      rst();
      t_regs();
      t_vectors();
      t_prio();
      t_edge();
      t_sources();
      t_idle();
      t_pd(1'b0);
      t_pd(1'b1);
      t_reset_pd();
      conclude();
   end
endmodule : testbench
`default_nettype wire
